// ===== hw/tlc_pkg.sv
// tlc_pkg: constants and types for the timer load, compare and count block.
// assumes a 32-bit APB register bus and a single timer clock domain.
package tlc_pkg;

   // counter width and limits
   localparam int CNT_W = 24;
   localparam logic [23:0] CNT_MAX = 24'hffffff;
   localparam logic [23:0] CNT_ZERO = 24'h000000;

   // register byte offsets
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_MASK = 8'h08;
   localparam logic [7:0] OFS_PRELOAD = 8'h0c;
   localparam logic [7:0] OFS_COMPARE = 8'h10;
   localparam logic [7:0] OFS_READBACK = 8'h14;

   // timer_control_status field positions
   localparam int CTRL_TE = 0;
   localparam int CTRL_RELOAD = 1;
   localparam int CTRL_CMP_IE = 2;
   localparam int CTRL_OVF_IE = 3;
   localparam int CTRL_MODE_LO = 4;
   localparam int CTRL_INV = 6;

   // sticky status bits, same layout in the mask register
   localparam int ST_W = 3;
   localparam int ST_CMP = 0;
   localparam int ST_OVF = 1;
   localparam int ST_CAP = 2;

   // values after reset
   localparam logic [2:0] ST_RESET = 3'h0;
   localparam logic [2:0] MASK_RESET = 3'h7;
   localparam logic [23:0] PRELOAD_RESET = 24'h000000;
   localparam logic [23:0] COMPARE_RESET = 24'hffffff;

   // mode class of the channel
   typedef enum logic [1:0] {
      TLC_MODE_TIMER = 2'b00,
      TLC_MODE_MEAS = 2'b01,
      TLC_MODE_PWM = 2'b10,
      TLC_MODE_WDOG = 2'b11
   } tlc_mode_t;

endpackage : tlc_pkg

// ===== hw/tlc_timer.sv
// tlc_timer: preload, compare and count-capture logic of one 24-bit timer channel.
// assumes an APB master on i_mclk, a count event pulse from the prescaler on the
// same clock, and an asynchronous timer io pin input.
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps

// Functional notes
// - first event after enable loads preload
// - timer mode reloads after compare match
// - measurement reloads on every qualifying edge
// - pwm mode reloads after counter overflow
// - watchdog reloads after compare match
// - watchdog preload write while enabled reloads
// - reload option clear means free running
// - 24-bit compare value checked on every count event
// - match sets flag, interrupt needs enable
// - measurement modes ignore compare value
// - readback shows live counter in timer/watchdog
// - measurement latches counter on qualifying edge
// - measurement input comes from io pin
// - enable clears counter, disable stops it
// - counter wraps to zero, overflow interrupt
// - compare after M minus N plus one
module tlc_timer (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rstn,
   // apb slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // timing inputs
   input wire logic i_count_event,
   input wire logic i_timer_io_pin,
   // interrupt
   output logic o_irq
);

   logic te;
   logic reload_option;
   logic compare_irq_enable;
   logic overflow_irq_enable;
   tlc_pkg::tlc_mode_t mode;
   logic inv;
   logic [2:0] status;
   logic [2:0] mask;
   logic [23:0] counter_preload;
   logic [23:0] counter_compare_value;
   logic [23:0] cnt;
   logic [23:0] capture;
   logic first_pending;
   logic wrapped;
   logic [31:0] prdata;
   logic pin_s1, pin_s2, pin_s3;

   logic next_te, next_reload, next_cmp_ie, next_ovf_ie, next_inv;
   tlc_pkg::tlc_mode_t next_mode;
   logic [2:0] next_status, next_mask;
   logic [23:0] next_preload, next_compare, next_cnt, next_capture;
   logic next_first, next_wrapped;
   logic [31:0] next_prdata;

   logic acc, wr, rd_setup, mapped;
   logic ctrl_wr, pl_wr, te_start, meas, qual_edge, cnt_evt, cmp_hit, ovf_hit;
   logic [23:0] readback;
   logic [2:0] set_bits, clr_bits, eff_mask;

   // apb decode
   assign acc = i_psel && i_penable;
   assign wr = acc && i_pwrite;
   assign rd_setup = i_psel && !i_penable && !i_pwrite;
   assign mapped = (i_paddr == tlc_pkg::OFS_CTRL) || (i_paddr == tlc_pkg::OFS_STATUS) ||
                   (i_paddr == tlc_pkg::OFS_MASK) || (i_paddr == tlc_pkg::OFS_PRELOAD) ||
                   (i_paddr == tlc_pkg::OFS_COMPARE) || (i_paddr == tlc_pkg::OFS_READBACK);
   assign o_pready = acc;
   assign o_pslverr = acc && !mapped;
   assign o_prdata = prdata;
   assign ctrl_wr = wr && (i_paddr == tlc_pkg::OFS_CTRL);
   assign pl_wr = wr && (i_paddr == tlc_pkg::OFS_PRELOAD);
   assign te_start = ctrl_wr && i_pwdata[tlc_pkg::CTRL_TE] && !te;

   // measured input is the io pin after a two-flop synchroniser
   assign meas = (mode == tlc_pkg::TLC_MODE_MEAS);
   assign qual_edge = te && meas && (inv ? (pin_s3 && !pin_s2) : (!pin_s3 && pin_s2));
   assign readback = meas ? capture : cnt;

   // counter path
   always_comb begin
      next_cnt = cnt;
      next_first = first_pending;
      next_wrapped = wrapped;
      next_capture = capture;
      cnt_evt = 1'b0;
      ovf_hit = 1'b0;
      if (te_start) begin
         next_cnt = tlc_pkg::CNT_ZERO;
         next_first = 1'b1;
         next_wrapped = 1'b0;
      end else if (!te) begin
         next_cnt = cnt;
      end else if (pl_wr && (mode == tlc_pkg::TLC_MODE_WDOG)) begin
         next_cnt = i_pwdata[23:0];
         next_first = 1'b0;
         next_wrapped = 1'b0;
      end else if (qual_edge) begin
         next_capture = cnt;
         if (reload_option) begin
            next_cnt = counter_preload;
            next_first = 1'b0;
         end
      end else if (i_count_event) begin
         cnt_evt = 1'b1;
         next_wrapped = 1'b0;
         if (first_pending) begin
            next_cnt = counter_preload;
            next_first = 1'b0;
         end else if (reload_option && !meas && (mode != tlc_pkg::TLC_MODE_PWM) &&
                      (cnt == counter_compare_value)) begin
            next_cnt = counter_preload;
         end else if (reload_option && (mode == tlc_pkg::TLC_MODE_PWM) && wrapped) begin
            next_cnt = counter_preload;
         end else begin
            next_cnt = cnt + 24'h000001;
            if (cnt == tlc_pkg::CNT_MAX) begin
               ovf_hit = 1'b1;
               next_wrapped = 1'b1;
            end
         end
      end
   end

   // compare runs while enabled, never in measurement modes
   assign cmp_hit = te && !meas && cnt_evt && (next_cnt == counter_compare_value);

   // sticky status: set wins over the read clear
   assign set_bits = {qual_edge, ovf_hit, cmp_hit};
   assign clr_bits = (acc && !i_pwrite && (i_paddr == tlc_pkg::OFS_STATUS)) ?
                     prdata[2:0] : 3'h0;
   assign eff_mask = mask & {1'b1, overflow_irq_enable, compare_irq_enable};
   assign o_irq = |(status & eff_mask);

   // register file next values
   always_comb begin
      next_te = te;
      next_reload = reload_option;
      next_cmp_ie = compare_irq_enable;
      next_ovf_ie = overflow_irq_enable;
      next_mode = mode;
      next_inv = inv;
      next_mask = mask;
      next_preload = counter_preload;
      next_compare = counter_compare_value;
      next_status = (status & ~clr_bits) | set_bits;
      next_prdata = prdata;
      if (ctrl_wr) begin
         next_te = i_pwdata[tlc_pkg::CTRL_TE];
         next_reload = i_pwdata[tlc_pkg::CTRL_RELOAD];
         next_cmp_ie = i_pwdata[tlc_pkg::CTRL_CMP_IE];
         next_ovf_ie = i_pwdata[tlc_pkg::CTRL_OVF_IE];
         next_mode = tlc_pkg::tlc_mode_t'(i_pwdata[tlc_pkg::CTRL_MODE_LO +: 2]);
         next_inv = i_pwdata[tlc_pkg::CTRL_INV];
      end
      if (wr && (i_paddr == tlc_pkg::OFS_MASK)) begin
         next_mask = i_pwdata[2:0];
      end
      if (pl_wr) begin
         next_preload = i_pwdata[23:0];
      end
      if (wr && (i_paddr == tlc_pkg::OFS_COMPARE)) begin
         next_compare = i_pwdata[23:0];
      end
      // read data is sampled in the setup cycle
      if (rd_setup) begin
         case (i_paddr)
            tlc_pkg::OFS_CTRL: next_prdata = {25'h0000000, inv, mode, overflow_irq_enable,
                                              compare_irq_enable, reload_option, te};
            tlc_pkg::OFS_STATUS: next_prdata = {29'h00000000, status};
            tlc_pkg::OFS_MASK: next_prdata = {29'h00000000, mask};
            tlc_pkg::OFS_COMPARE: next_prdata = {8'h00, counter_compare_value};
            tlc_pkg::OFS_READBACK: next_prdata = {8'h00, readback};
            default: next_prdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         te <= 1'b0;
         reload_option <= 1'b0;
         compare_irq_enable <= 1'b0;
         overflow_irq_enable <= 1'b0;
         mode <= tlc_pkg::TLC_MODE_TIMER;
         inv <= 1'b0;
         mask <= tlc_pkg::MASK_RESET;
         status <= tlc_pkg::ST_RESET;
         counter_preload <= tlc_pkg::PRELOAD_RESET;
         counter_compare_value <= tlc_pkg::COMPARE_RESET;
         cnt <= tlc_pkg::CNT_ZERO;
         capture <= tlc_pkg::CNT_ZERO;
         first_pending <= 1'b0;
         wrapped <= 1'b0;
         prdata <= 32'h00000000;
         pin_s1 <= 1'b0;
         pin_s2 <= 1'b0;
         pin_s3 <= 1'b0;
      end else begin
         te <= next_te;
         reload_option <= next_reload;
         compare_irq_enable <= next_cmp_ie;
         overflow_irq_enable <= next_ovf_ie;
         mode <= next_mode;
         inv <= next_inv;
         mask <= next_mask;
         status <= next_status;
         counter_preload <= next_preload;
         counter_compare_value <= next_compare;
         cnt <= next_cnt;
         capture <= next_capture;
         first_pending <= next_first;
         wrapped <= next_wrapped;
         prdata <= next_prdata;
         pin_s1 <= i_timer_io_pin;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
      end
   end

   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rstn);

   a_first_load: assert property (te && first_pending && i_count_event && !ctrl_wr && !pl_wr
      && !qual_edge |=> cnt == $past(counter_preload))
      else $error("first event did not load preload");
   a_cmp_reload: assert property (te && !first_pending && i_count_event && reload_option
      && !meas && mode != tlc_pkg::TLC_MODE_PWM && cnt == counter_compare_value
      && !ctrl_wr && !pl_wr |=> cnt == $past(counter_preload))
      else $error("no reload after compare match");
   a_meas_reload: assert property (qual_edge && reload_option && !ctrl_wr && !pl_wr
      |=> cnt == $past(counter_preload))
      else $error("no reload on measured edge");
   a_pwm_reload: assert property (te && mode == tlc_pkg::TLC_MODE_PWM && wrapped
      && reload_option && i_count_event && !first_pending && !ctrl_wr && !pl_wr
      |=> cnt == $past(counter_preload))
      else $error("no reload after pwm overflow");
   a_wdog_write: assert property (te && pl_wr && mode == tlc_pkg::TLC_MODE_WDOG
      |=> cnt == $past(i_pwdata[23:0]))
      else $error("watchdog preload write did not reload");
   a_free_run: assert property (te && !reload_option && !first_pending && i_count_event
      && !ctrl_wr && !pl_wr && !qual_edge |=> cnt == $past(cnt) + 24'h000001)
      else $error("free running counter did not advance");
   a_cmp_flag: assert property (cmp_hit |=> status[tlc_pkg::ST_CMP] [*2])
      else $error("compare flag not held");
   a_meas_ignore: assert property (meas |-> !cmp_hit)
      else $error("compare matched in measurement mode");
   a_readback: assert property (rd_setup && i_paddr == tlc_pkg::OFS_READBACK && !meas
      |=> prdata == {8'h00, $past(cnt)})
      else $error("readback did not show live counter");
   a_capture: assert property (qual_edge |=> capture == $past(cnt))
      else $error("capture missed counter value");
   a_enable_clear: assert property (te_start |=> cnt == tlc_pkg::CNT_ZERO && first_pending)
      else $error("enable did not clear counter");
   a_wrap_ovf: assert property (ovf_hit |=> cnt == tlc_pkg::CNT_ZERO
      && status[tlc_pkg::ST_OVF])
      else $error("overflow did not wrap or flag");

   c_cmp_irq: cover property (cmp_hit && compare_irq_enable ##1 o_irq);
   c_meas_edge: cover property (qual_edge && reload_option);
   c_overflow: cover property (ovf_hit && mode == tlc_pkg::TLC_MODE_PWM);
   c_wdog_kick: cover property (pl_wr && te && mode == tlc_pkg::TLC_MODE_WDOG);

endmodule : tlc_timer

// ===== sim/testbench.sv
// testbench: self-checking bench for tlc_timer.
// assumes tlc_pkg and tlc_pin_src are compiled first.
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
   $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module testbench;
   logic i_mclk = 0, i_rstn = 0, i_psel = 0, i_penable = 0, i_pwrite = 0, i_count_event = 0;
   logic [7:0] i_paddr = 8'h00;
   logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
   logic o_pready, o_pslverr, o_irq, pin, err;
   int errors = 0, tests_run = 0;
   int unsigned seed = 38501;
   logic [23:0] n, k;
   tlc_timer i_dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_psel(i_psel), .i_penable(i_penable),
      .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
      .o_pready(o_pready), .o_pslverr(o_pslverr), .i_count_event(i_count_event),
      .i_timer_io_pin(pin), .o_irq(o_irq));
   tlc_pin_src i_src (.i_mclk(i_mclk), .o_pin(pin));
   initial begin
      forever #25 i_mclk = ~i_mclk;
   end
   function automatic logic [23:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[23:0];
   endfunction : rnd
   // control word: mode, reload option, both interrupt enables, enable
   function automatic logic [31:0] cw(input logic [1:0] md, input logic rl);
      return {26'h0, md, 2'b11, rl, 1'b1};
   endfunction : cw
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_mclk);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_mclk);
      i_penable <= 1'b1;
      // no local limit: only the watchdog ends a wait
      do begin
         @(posedge i_mclk);
      end while (o_pready !== 1'b1);
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      // one idle edge so registers written at the access edge show on the outputs
      @(posedge i_mclk);
   endtask : apb
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      `CHK(rd, exp)
   endtask : rdchk
   // count events spaced so status and irq have settled on return
   task automatic ev(input int c);
      repeat (c) begin
         @(posedge i_mclk);
         i_count_event <= 1'b1;
         @(posedge i_mclk);
         i_count_event <= 1'b0;
         repeat (3) @(posedge i_mclk);
      end
   endtask : ev
   task automatic give_verdict();
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : give_verdict
   initial begin
      #(50 * 20000);
      errors++;
      give_verdict();
   end
   initial begin
      repeat (12) @(posedge i_mclk);
      i_rstn <= 1'b1;
      rdchk(tlc_pkg::OFS_CTRL, 32'h0);
      rdchk(tlc_pkg::OFS_MASK, 32'h7);
      rdchk(tlc_pkg::OFS_COMPARE, 32'hffffff);
      apb(1'b1, 8'h18, 32'h1);
      `CHK(err, 1'b1)
      // timer mode then watchdog mode, reload on
      for (int m = 0; m < 2; m++) begin
         n = rnd() & 24'h7fffff;
         k = 24'h2 + (rnd() % 4);
         apb(1'b1, tlc_pkg::OFS_PRELOAD, {8'h0, n});
         rdchk(tlc_pkg::OFS_PRELOAD, 32'h0);
         apb(1'b1, tlc_pkg::OFS_COMPARE, {8'h0, n + k});
         rdchk(tlc_pkg::OFS_COMPARE, {8'h0, n + k});
         apb(1'b1, tlc_pkg::OFS_CTRL, cw(m ? 2'b11 : 2'b00, 1'b1));
         rdchk(tlc_pkg::OFS_READBACK, 32'h0);
         ev(k);
         rdchk(tlc_pkg::OFS_READBACK, {8'h0, n + k - 24'h1});
         `CHK(o_irq, 1'b0)
         ev(1);
         `CHK(o_irq, 1'b1)
         apb(1'b1, tlc_pkg::OFS_MASK, 32'h0);
         `CHK(o_irq, 1'b0)
         apb(1'b1, tlc_pkg::OFS_MASK, 32'h7);
         ev(1);
         rdchk(tlc_pkg::OFS_READBACK, {8'h0, n});
         rdchk(tlc_pkg::OFS_STATUS, 32'h1);
         rdchk(tlc_pkg::OFS_STATUS, 32'h0);
         `CHK(o_irq, 1'b0)
         if (m) begin
            apb(1'b1, tlc_pkg::OFS_PRELOAD, {8'h0, ~n});
            rdchk(tlc_pkg::OFS_READBACK, {8'h0, ~n});
         end
         apb(1'b1, tlc_pkg::OFS_CTRL, 32'h0);
      end
      // free running past the compare value
      apb(1'b1, tlc_pkg::OFS_PRELOAD, {8'h0, n});
      apb(1'b1, tlc_pkg::OFS_COMPARE, {8'h0, n + 24'h1});
      apb(1'b1, tlc_pkg::OFS_CTRL, cw(2'b00, 1'b0));
      ev(3);
      rdchk(tlc_pkg::OFS_READBACK, {8'h0, n + 24'h2});
      rdchk(tlc_pkg::OFS_STATUS, 32'h1);
      apb(1'b1, tlc_pkg::OFS_CTRL, 32'h0);
      // pwm: wrap to zero, then reload
      apb(1'b1, tlc_pkg::OFS_PRELOAD, 32'hfffffe);
      apb(1'b1, tlc_pkg::OFS_COMPARE, 32'h5);
      apb(1'b1, tlc_pkg::OFS_CTRL, cw(2'b10, 1'b1));
      ev(3);
      rdchk(tlc_pkg::OFS_READBACK, 32'h0);
      `CHK(o_irq, 1'b1)
      rdchk(tlc_pkg::OFS_STATUS, 32'h2);
      ev(1);
      rdchk(tlc_pkg::OFS_READBACK, 32'hfffffe);
      apb(1'b1, tlc_pkg::OFS_CTRL, 32'h0);
      // disabled: events leave the counter alone
      ev(1);
      rdchk(tlc_pkg::OFS_READBACK, 32'hfffffe);
      // measurement: compare ignored, capture and reload on rising edge
      apb(1'b1, tlc_pkg::OFS_PRELOAD, {8'h0, n});
      apb(1'b1, tlc_pkg::OFS_COMPARE, {8'h0, n + 24'h1});
      apb(1'b1, tlc_pkg::OFS_CTRL, cw(2'b01, 1'b1));
      ev(3);
      i_src.pulse(4);
      repeat (6) @(posedge i_mclk);
      rdchk(tlc_pkg::OFS_READBACK, {8'h0, n + 24'h2});
      ev(1);
      i_src.pulse(4);
      repeat (6) @(posedge i_mclk);
      rdchk(tlc_pkg::OFS_READBACK, {8'h0, n + 24'h1});
      rdchk(tlc_pkg::OFS_STATUS, 32'h4);
      // falling edge qualifies with invert set, reload off: events at both edges differ
      apb(1'b1, tlc_pkg::OFS_CTRL, cw(2'b01, 1'b0) | 32'h40);
      fork
         i_src.pulse(4);
         ev(2);
      join
      repeat (6) @(posedge i_mclk);
      rdchk(tlc_pkg::OFS_READBACK, {8'h0, n + 24'h2});
      rdchk(tlc_pkg::OFS_STATUS, 32'h4);
      give_verdict();
   end
endmodule : testbench

// ===== sim/tlc_pin_src.sv
// tlc_pin_src: far-side source of the timer io pin in measurement modes.
// assumes the bench calls pulse() from its main sequence; the pin idles low.
`timescale 1ns/10ps
module tlc_pin_src (
   // clock
   input wire logic i_mclk,
   // pin
   output logic o_pin
);
   initial o_pin = 1'b0;
   // one high pulse, changed just after rising edges
   task automatic pulse(input int width);
      @(posedge i_mclk);
      o_pin <= 1'b1;
      repeat (width) @(posedge i_mclk);
      o_pin <= 1'b0;
   endtask : pulse
endmodule : tlc_pin_src
